// ==== design/plcx_regs.v ====
/*
 contents: phy output control and misc host configuration registers, eeprom preload of the phy control register only
 assumes: config write/read strobes on SYS_CLK_I; eeprom loader gives byte strobes
*/
`timescale 1ns/1ps
`default_nettype none
`include "plcx_defs.vh"
module plcx_regs (
   input  wire        SYS_CLK_I,
   input  wire        RESETN_I,
   input  wire        GLOBAL_RESET_N_I,
   input  wire        CE_I,
   input  wire        CFG_WR_I,
   input  wire        CFG_RD_I,
   input  wire [7:0]  CFG_ADDR_I,
   input  wire [3:0]  CFG_BE_I,
   input  wire [31:0] CFG_WDATA_I,
   output reg  [31:0] CFG_RDATA_O,
   output reg         CFG_ACK_O,
   input  wire        EE_VALID_I,
   input  wire [7:0]  EE_ADDR_I,
   input  wire [7:0]  EE_DATA_I,
   input  wire        CABLE_NOT_ACTIVE_I,
   input  wire        UNMASKED_IRQ_I,
   input  wire        MASTER_IRQ_EN_I,
   output reg         CABLE_NOT_ACTIVE_O,
   output reg         WAKE_FROM_COLD_SUPPORT_O,
   output reg         NEWER_BUS_REV_SELECT_O,
   output reg         VENDOR_ID_BIT26_O,
   output reg         WAKE_REQ_O
);
   reg         cable_inactive_route_en;
   reg         comply_bit;
   reg         wake_from_cold_support;
   reg         newer_bus_rev_select;
   reg         wake_ignores_master_irq_gate;
   reg         next_route;
   reg         next_comply;
   reg         next_cold;
   reg         next_rev;
   reg         next_ign;
   reg  [31:0] phy_image;
   reg  [31:0] misc_image;
   reg  [31:0] next_rdata;
   wire        cna_sync;
   wire        ee_phy_hit;
   wire        wr_phy_lane0;
   wire        wr_misc_lane1;
   wire        rd_phy;
   wire        rd_misc;
   wire [31:0] phy_keep;
   wire [31:0] misc_keep;
   genvar      gi;

   function hit;
      input [7:0] a;
      input [7:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   function in_mask;
      input [31:0] mask;
      input integer idx;
      begin
         in_mask = mask[idx];
      end
   endfunction

   plcx_sync3 u_cna_sync (
      .clk_i   (SYS_CLK_I),
      .rst_n_i (RESETN_I),
      .ce_i    (CE_I),
      .d_i     (CABLE_NOT_ACTIVE_I),
      .q_o     (cna_sync)
   );

   // access decode
   assign ee_phy_hit    = EE_VALID_I & hit(EE_ADDR_I, `PLCX_EE_OFF_PHY);
   assign wr_phy_lane0  = CFG_WR_I &
                          hit(CFG_ADDR_I, `PLCX_OFF_PHY_CTRL) &
                          CFG_BE_I[`PLCX_LANE_PHY];
   assign wr_misc_lane1 = CFG_WR_I &
                          hit(CFG_ADDR_I, `PLCX_OFF_MISC_CFG) &
                          CFG_BE_I[`PLCX_LANE_MISC];
   assign rd_phy        = hit(CFG_ADDR_I, `PLCX_OFF_PHY_CTRL);
   assign rd_misc       = hit(CFG_ADDR_I, `PLCX_OFF_MISC_CFG);

   // readable bit masks, one per field position
   generate
      for (gi = 0; gi < `PLCX_WORD_W; gi = gi + 1) begin : g_keep
         assign phy_keep[gi]  = in_mask(`PLCX_PHY_RD_MASK, gi);
         assign misc_keep[gi] = in_mask(`PLCX_MISC_RD_MASK, gi);
      end
   endgenerate

   // phy control next value, eeprom byte beats a same-cycle write
   always @* begin
      next_route  = cable_inactive_route_en;
      next_comply = comply_bit;
      if (ee_phy_hit) begin
         next_route  = EE_DATA_I[`PLCX_BIT_ROUTE];
         next_comply = EE_DATA_I[`PLCX_BIT_COMPLY];
      end else if (wr_phy_lane0) begin
         next_route  = CFG_WDATA_I[`PLCX_BIT_ROUTE];
      end
   end

   // misc next value, lane 1 only
   always @* begin
      next_cold = wake_from_cold_support;
      next_rev  = newer_bus_rev_select;
      next_ign  = wake_ignores_master_irq_gate;
      if (wr_misc_lane1) begin
         next_cold = CFG_WDATA_I[`PLCX_BIT_COLD];
         next_rev  = CFG_WDATA_I[`PLCX_BIT_REV23];
         next_ign  = CFG_WDATA_I[`PLCX_BIT_IGN_GATE];
      end
   end

   // sticky phy bits: global reset only
   always @(posedge SYS_CLK_I) begin
      if (!GLOBAL_RESET_N_I) begin
         cable_inactive_route_en <= `PLCX_ROUTE_RESET;
         comply_bit              <= `PLCX_COMPLY_RESET;
      end else if (CE_I) begin
         cable_inactive_route_en <= next_route;
         comply_bit              <= next_comply;
      end
   end

   // sticky misc bits: global reset only
   always @(posedge SYS_CLK_I) begin
      if (!GLOBAL_RESET_N_I) begin
         wake_from_cold_support       <= `PLCX_MISC_BIT_RST;
         newer_bus_rev_select         <= `PLCX_MISC_BIT_RST;
         wake_ignores_master_irq_gate <= `PLCX_MISC_BIT_RST;
      end else if (CE_I) begin
         wake_from_cold_support       <= next_cold;
         newer_bus_rev_select         <= next_rev;
         wake_ignores_master_irq_gate <= next_ign;
      end
   end

   // register images at their field positions
   always @* begin
      phy_image                       = {`PLCX_WORD_W{1'b0}};
      misc_image                      = {`PLCX_WORD_W{1'b0}};
      phy_image[`PLCX_BIT_ROUTE]      = cable_inactive_route_en;
      phy_image[`PLCX_BIT_COMPLY]     = comply_bit;
      misc_image[`PLCX_BIT_COLD]      = wake_from_cold_support;
      misc_image[`PLCX_BIT_REV23]     = newer_bus_rev_select;
      misc_image[`PLCX_BIT_IGN_GATE]  = wake_ignores_master_irq_gate;
   end

   // read mux, reserved bits masked to zero
   always @* begin
      next_rdata = {`PLCX_WORD_W{1'b0}};
      if (rd_phy) begin
         next_rdata = phy_image & phy_keep;
      end else if (rd_misc) begin
         next_rdata = misc_image & misc_keep;
      end
   end

   always @(posedge SYS_CLK_I) begin
      if (!RESETN_I) begin
         CFG_RDATA_O              <= 32'h00000000;
         CFG_ACK_O                <= 1'b0;
         CABLE_NOT_ACTIVE_O       <= 1'b0;
         WAKE_FROM_COLD_SUPPORT_O <= 1'b0;
         NEWER_BUS_REV_SELECT_O   <= 1'b0;
         VENDOR_ID_BIT26_O        <= 1'b0;
         WAKE_REQ_O               <= 1'b0;
      end else if (CE_I) begin
         CFG_ACK_O   <= CFG_RD_I | CFG_WR_I;
         CFG_RDATA_O <= CFG_RD_I ? next_rdata : 32'h00000000;
         CABLE_NOT_ACTIVE_O       <= cable_inactive_route_en & cna_sync;
         WAKE_FROM_COLD_SUPPORT_O <= wake_from_cold_support;
         NEWER_BUS_REV_SELECT_O   <= newer_bus_rev_select;
         VENDOR_ID_BIT26_O        <= wake_ignores_master_irq_gate;
         WAKE_REQ_O <= UNMASKED_IRQ_I &
                       (MASTER_IRQ_EN_I | wake_ignores_master_irq_gate);
      end
   end
endmodule // plcx_regs
`default_nettype wire

// ==== include/plcx_defs.vh ====
/*
 contents: constants for the phy output control and misc host configuration registers
 assumes: included by the design files of this block by bare name
*/
`ifndef PLCX_DEFS_VH
`define PLCX_DEFS_VH
`define PLCX_ADDR_W        8
`define PLCX_OFF_PHY_CTRL  8'hec
`define PLCX_OFF_MISC_CFG  8'hf0
`define PLCX_PHY_RESET     32'h00000008
`define PLCX_MISC_RESET    32'h00000000
`define PLCX_BIT_ROUTE     7
`define PLCX_BIT_COMPLY    3
`define PLCX_BIT_COLD      15
`define PLCX_BIT_REV23     11
`define PLCX_BIT_IGN_GATE  10
`define PLCX_EE_OFF_PHY    8'h16
`define PLCX_PMC_BIT_COLD  15
`define PLCX_VID_BIT_IGN   26
`define PLCX_WORD_W        32
`define PLCX_LANE_PHY      0
`define PLCX_LANE_MISC     1
`define PLCX_PHY_RD_MASK   32'h00000088
`define PLCX_MISC_RD_MASK  32'h00008c00
`define PLCX_ROUTE_RESET   1'b0
`define PLCX_COMPLY_RESET  1'b1
`define PLCX_MISC_BIT_RST  1'b0
`endif

// ==== design/plcx_sync3.v ====
/*
 contents: three flop synchroniser, change accepted when stages two and three agree
 assumes: one clock, synchronous active low reset, clock enable
*/
`timescale 1ns/1ps
`default_nettype none
module plcx_sync3 (
   input  wire clk_i,
   input  wire rst_n_i,
   input  wire ce_i,
   input  wire d_i,
   output reg  q_o
);
   reg [2:0] stage;
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         stage <= 3'h0;
         q_o   <= 1'b0;
      end else if (ce_i) begin
         stage <= {stage[1:0], d_i};
         if (stage[1] == stage[2]) begin
            q_o <= stage[2];
         end
      end
   end
endmodule // plcx_sync3
`default_nettype wire

// ==== tb/plcx_regs_checker.sv ====
/* assertions on the plcx_regs ports
   assumes: bound to every plcx_regs instance, ports matched by name */
`timescale 1ns/1ps
`default_nettype none
module plcx_regs_checker (
   input wire logic SYS_CLK_I, RESETN_I, GLOBAL_RESET_N_I, CE_I, CFG_WR_I, CFG_RD_I,
   input wire logic [7:0]  CFG_ADDR_I,
   input wire logic [3:0]  CFG_BE_I,
   input wire logic [31:0] CFG_WDATA_I, CFG_RDATA_O,
   input wire logic CABLE_NOT_ACTIVE_I, UNMASKED_IRQ_I, MASTER_IRQ_EN_I, CFG_ACK_O,
   input wire logic CABLE_NOT_ACTIVE_O, WAKE_FROM_COLD_SUPPORT_O, NEWER_BUS_REV_SELECT_O,
   input wire logic VENDOR_ID_BIT26_O, WAKE_REQ_O
);
   wire [2:0] wsel = {CFG_WDATA_I[15], CFG_WDATA_I[11:10]};
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!RESETN_I || !GLOBAL_RESET_N_I);
   sequence rd_at(a); CE_I && CFG_RD_I && CFG_ADDR_I == a; endsequence
   sequence wr_misc; CE_I && CFG_WR_I && CFG_ADDR_I == 8'hf0 && CFG_BE_I[1]; endsequence
   sequence irq(m); CE_I && UNMASKED_IRQ_I && MASTER_IRQ_EN_I == m; endsequence
   a_ack_follows: assert property (CE_I && (CFG_WR_I || CFG_RD_I) |=> CFG_ACK_O)
      else $error("ack missing");
   a_phy_read: assert property (
      rd_at(8'hec) |=> CFG_RDATA_O[31:8] == 0 && CFG_RDATA_O[6:0] == 7'h08) else $error("phy");
   a_misc_read: assert property (
      rd_at(8'hf0) |=> CFG_RDATA_O[31:16] == 0 && CFG_RDATA_O[14:12] == 0) else $error("misc");
   a_cna_blocked: assert property (!CABLE_NOT_ACTIVE_I [*6] |=> !CABLE_NOT_ACTIVE_O)
      else $error("cna");
   a_misc_outs: assert property (
      wr_misc |-> ##2 {WAKE_FROM_COLD_SUPPORT_O, NEWER_BUS_REV_SELECT_O, VENDOR_ID_BIT26_O}
      == $past(wsel, 2)) else $error("misc outs");
   a_wake_gated: assert property (irq(1) |=> WAKE_REQ_O) else $error("wake");
   a_wake_ignore: assert property (irq(0) |=> WAKE_REQ_O == VENDOR_ID_BIT26_O)
      else $error("wake ign");
   a_wake_no_irq: assert property (CE_I && !UNMASKED_IRQ_I |=> !WAKE_REQ_O)
      else $error("wake idle");
endmodule // plcx_regs_checker
bind plcx_regs plcx_regs_checker i_chk (.*);
`default_nettype wire

// ==== tb/plcx_ee_model.sv ====
/* eeprom loader model: one byte strobe to offset 16h per start pulse
   assumes: start and route driven by the bench */
`timescale 1ns/1ps
`default_nettype none
module plcx_ee_model (
   input  wire logic       clk_i,
   input  wire logic       start_i,
   input  wire logic       route_i,
   output var  logic       valid_o = 0,
   output var  logic [7:0] addr_o = 0,
   output var  logic [7:0] data_o = 0
);
   always @(posedge clk_i) begin
      valid_o <= start_i;
      addr_o  <= start_i ? 8'h16 : ~addr_o;
      data_o  <= start_i ? {route_i, 7'h08} : ~data_o;
   end
endmodule // plcx_ee_model
`default_nettype wire

// ==== tb/plcx_regs_tb.sv ====
/* self-checking bench for plcx_regs
   assumes: checker and eeprom model compiled first */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; \
   $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module plcx_regs_tb;
   logic c = 0, r = 0, g = 0, w = 0, rd = 0, cable_not_active = 0, irq = 0, men = 0, go = 0, rt = 0;
   logic [7:0] a = 0;
   logic ce = 1;
   logic [3:0] be = 4'hf;
   logic [31:0] wd = 0, d, e;
   wire logic [31:0] rdt;
   wire logic ack, co, cold, rev, vid, wk, ev;
   wire logic [7:0] ea, ed;
   logic [31:0] q[$];
   int n_fail = 0, check_count = 0;
   initial forever #2.5 c = ~c;
   plcx_ee_model i_ee (.clk_i(c), .start_i(go), .route_i(rt), .valid_o(ev), .addr_o(ea),
      .data_o(ed));
   plcx_regs i_dut (.SYS_CLK_I(c), .RESETN_I(r), .GLOBAL_RESET_N_I(g), .CE_I(ce),
      .CFG_WR_I(w), .CFG_RD_I(rd), .CFG_ADDR_I(a), .CFG_BE_I(be), .CFG_WDATA_I(wd),
      .CFG_RDATA_O(rdt), .CFG_ACK_O(ack), .EE_VALID_I(ev), .EE_ADDR_I(ea), .EE_DATA_I(ed),
      .CABLE_NOT_ACTIVE_I(cable_not_active), .UNMASKED_IRQ_I(irq), .MASTER_IRQ_EN_I(men),
      .CABLE_NOT_ACTIVE_O(co), .WAKE_FROM_COLD_SUPPORT_O(cold), .NEWER_BUS_REV_SELECT_O(rev),
      .VENDOR_ID_BIT26_O(vid), .WAKE_REQ_O(wk));
   always @(posedge c) if (ack) begin
      e = q.pop_front();
      `CHK(rdt, e)
   end
   task acc(input logic wr_n, input logic [7:0] ad, input logic [31:0] v, ex);
      w = !wr_n; rd = wr_n; a = ad; wd = v; q.push_back(ex);
      @(posedge c); #1;
   endtask
   task idle(input int n);
      w = 0; rd = 0;
      repeat (n) @(posedge c); #1;
   endtask
   task end_of_test;
      $display("checks %0d fails %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin #20000; n_fail++; end_of_test; end
   initial begin
      void'($urandom(20));
      repeat (10) @(posedge c); #1;
      r = 1; g = 1;
      acc(1, 8'hec, 0, 8); acc(1, 8'hf0, 0, 0); acc(1, 8'h40, 0, 0); idle(1);
      $display("reset test done");
      for (int i = 0; i < 2; i++) begin
         d = $urandom; d[7] = i[0]; cable_not_active = 1;
         acc(0, 8'hec, d, 0); acc(1, 8'hec, 0, {d[7], 7'h08}); idle(8);
         `CHK(co, d[7])
         cable_not_active = 0; idle(8);
         `CHK(co, 1'b0)
      end
      $display("phy test done");
      for (int i = 0; i < 8; i++) begin
         d = ($urandom & 32'hffff7000) | {i[2], 3'h0, i[1:0], 10'h0}; irq = $urandom; men = $urandom;
         acc(0, 8'hf0, d, 0); acc(1, 8'hf0, 0, d & 32'h8c00); idle(1);
         `CHK({cold, rev, vid, wk}, {d[15], d[11:10], irq & (men | d[10])})
      end
      be = 4'he; acc(0, 8'hec, 0, 0); acc(1, 8'hec, 0, 32'h88); be = 4'hf; idle(1);
      ce = 0; w = 1; a = 8'hf0; wd = 0; repeat (3) @(posedge c); #1;
      w = 0; ce = 1;
      acc(1, 8'hf0, 0, 32'h8c00); idle(1);
      `CHK(cold, 1'b1)
      $display("misc test done");
      rt = 1; go = 1; idle(1); go = 0; idle(2);
      acc(1, 8'hec, 0, 32'h88); idle(1);
      r = 0; idle(2);
      `CHK({cold, rev, vid}, 3'h0)
      r = 1;
      acc(1, 8'hec, 0, 32'h88); idle(1);
      `CHK(cold, 1'b1)
      g = 0; idle(2); g = 1;
      acc(1, 8'hec, 0, 8); acc(1, 8'hf0, 0, 0); idle(2);
      `CHK({cold, rev, vid}, 3'h0)
      $display("load and reset test done");
      end_of_test;
   end
endmodule // plcx_regs_tb
`default_nettype wire
